/* File: design/stc_timer.sv */
// Operation
// - 16-bit up count, wraps ffff to 0000
// - Software reads and writes both count bytes
// - Wrap latches overflow flag bit 0
// - Interrupt request only when enable bit set
// - Control bit 1 picks internal or external
// - Control bit 0 runs or holds count
// - Bits 5:4 pick prescale 1,2,4,8
// - Bit 3 enables the low-power oscillator
// - Oscillator enabled forces both pins input
// - Bit 2 bypasses sync, external source only
// - Oscillator pin counted when oscillator enabled, external source only
// - Ripple prescaler; sync after its output
// - Synced mode frozen in sleep, prescaler runs
// - Unsynced mode runs in sleep, can wake
// - Unsynced count not a capture time base
// - Timer mode counts each instruction cycle
// - Capture/compare reset input clears count
// - Control bits 7:6 read as zero
// - Count byte write clears the prescaler
// - Software write beats capture/compare reset
// - Control resets to 00, count to 0000
//
// The AHB-Lite interface to the registers was chosen for this implementation.
module stc_timer
   import stc_pkg::*;
(
   input  wire logic        core_clk_in,
   input  wire logic        rst_in,
   input  wire logic        hsel_in,
   input  wire logic [31:0] haddr_in,
   input  wire logic [1:0]  htrans_in,
   input  wire logic        hwrite_in,
   input  wire logic [2:0]  hsize_in,
   input  wire logic [31:0] hwdata_in,
   input  wire logic        hready_in,
   output logic [31:0]      hrdata_out,
   output logic             hreadyout_out,
   output logic             hresp_out,
   input  wire logic        ext_clock_pin_in,
   input  wire logic        osc_input_pin_in,
   input  wire logic        sleep_in,
   input  wire logic        cc_reset_in,
   output logic [15:0]      count_out,
   output logic             time_base_valid_out,
   output logic             timer_irq_out,
   output logic             osc_enable_out,
   output logic             osc_pins_input_out
);

   typedef struct packed {
      logic        ext_s1;
      logic        ext_s2;
      logic        osc_s1;
      logic        osc_s2;
      logic [1:0]  phase;
      logic        samp;
      logic        samp_prev;
      logic        byp_prev;
      logic [7:0]  ctrl;
      logic [15:0] count;
      logic        flag;
      logic        irq_en;
      logic        irq;
      logic        tb_valid;
      logic        wr_pend;
      logic [9:0]  wr_idx;
      logic [31:0] rdata;
   } stc_state_t;

   localparam stc_state_t STATE_RESET = '{
      ctrl:     CTRL_RESET,
      count:    COUNT_RESET,
      tb_valid: 1'b1,
      default:  '0
   };

   stc_state_t s;
   stc_state_t next_s;

   logic       src_level;
   logic       pre_tap;
   logic       tick_sync;
   logic       tick_byp;
   logic       tick;
   logic       inc;
   logic       ovf;
   logic       wr_low;
   logic       wr_high;
   logic       wr_cnt;
   logic       addr_ok;
   logic [9:0] addr_idx;

   function automatic logic [9:0] reg_index(input logic [31:0] addr);
      reg_index = addr[11:2];
   endfunction

   function automatic logic [31:0] read_value(input logic [9:0] idx, input stc_state_t st);
      read_value = 32'h0;
      case (idx)
         IDX_LOW:    read_value = {24'h0, st.count[7:0]};
         IDX_HIGH:   read_value = {24'h0, st.count[15:8]};
         IDX_CTRL:   read_value = {24'h0, st.ctrl & CTRL_WMASK};
         IDX_FLAG:   read_value = {31'h0, st.flag};
         IDX_ENABLE: read_value = {31'h0, st.irq_en};
         default:    read_value = 32'h0;
      endcase
   endfunction

   // Oscillator pin replaces the clock pin when the oscillator runs
   assign src_level = s.ctrl[CTRL_CS_BIT]
                    ? (s.ctrl[CTRL_OSC_BIT] ? s.osc_s2 : s.ext_s2)
                    : s.phase[1];

   assign wr_low  = s.wr_pend && (s.wr_idx == IDX_LOW);
   assign wr_high = s.wr_pend && (s.wr_idx == IDX_HIGH);
   assign wr_cnt  = wr_low || wr_high;

   // Divider sits ahead of synchronisation, as the ripple stage does
   stc_prescaler u_prescaler (
      .clk_in    (core_clk_in),
      .rst_in    (rst_in),
      .level_in  (src_level),
      .clear_in  (wr_cnt),
      .select_in (s.ctrl[CTRL_PS_LSB +: 2]),
      .tap_out   (pre_tap)
   );

   assign tick_sync = s.samp && !s.samp_prev;
   assign tick_byp  = pre_tap && !s.byp_prev;

   // Sync bit only matters with the external source
   always_comb begin
      if (s.ctrl[CTRL_CS_BIT] && s.ctrl[CTRL_SYNC_BIT]) begin
         tick = tick_byp;
      end else begin
         tick = tick_sync && !sleep_in;
      end
   end

   assign inc      = tick && s.ctrl[CTRL_ON_BIT];
   assign ovf      = inc && (s.count == COUNT_MAX) && !wr_cnt && !cc_reset_in;
   assign addr_ok  = hsel_in && htrans_in[1] && hready_in;
   assign addr_idx = reg_index(haddr_in);

   always_comb begin
      next_s = s;

      // Pin synchronisers, first stage feeds the second only
      next_s.ext_s1 = ext_clock_pin_in;
      next_s.ext_s2 = s.ext_s1;
      next_s.osc_s1 = osc_input_pin_in;
      next_s.osc_s2 = s.osc_s1;

      // Instruction phases stop with the core clock in sleep
      if (!sleep_in) begin
         next_s.phase = 2'(s.phase + PHASE_STEP);
      end

      // Sample on the second and fourth phase
      if (s.phase[0]) begin
         next_s.samp = pre_tap;
      end
      next_s.samp_prev = s.samp;
      next_s.byp_prev  = pre_tap;

      // Bus address phase
      next_s.wr_pend = addr_ok && hwrite_in;
      next_s.wr_idx  = addr_idx;
      next_s.rdata   = (addr_ok && !hwrite_in) ? read_value(addr_idx, s) : 32'h0;

      // Count: write beats reset, reset beats increment
      if (wr_cnt) begin
         if (wr_low) begin
            next_s.count[7:0] = hwdata_in[7:0];
         end
         if (wr_high) begin
            next_s.count[15:8] = hwdata_in[7:0];
         end
      end else if (cc_reset_in) begin
         next_s.count = COUNT_RESET;
      end else if (inc) begin
         next_s.count = 16'(s.count + 16'h1);
      end

      if (s.wr_pend && (s.wr_idx == IDX_CTRL)) begin
         next_s.ctrl = hwdata_in[7:0] & CTRL_WMASK;
      end
      if (s.wr_pend && (s.wr_idx == IDX_ENABLE)) begin
         next_s.irq_en = hwdata_in[ENABLE_BIT];
      end

      // Set wins over a clear in the same cycle
      if (s.wr_pend && (s.wr_idx == IDX_FLAG)) begin
         next_s.flag = hwdata_in[FLAG_BIT];
      end
      if (ovf) begin
         next_s.flag = 1'b1;
      end

      next_s.irq      = next_s.flag && next_s.irq_en;
      next_s.tb_valid = !(next_s.ctrl[CTRL_CS_BIT] && next_s.ctrl[CTRL_SYNC_BIT]);
   end

   // Count resets with the power-on reset and clears on the capture/compare reset
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         s <= STATE_RESET;
      end else begin
         s <= next_s;
      end
   end

   assign hrdata_out          = s.rdata;
   assign hreadyout_out       = 1'b1;
   assign hresp_out           = 1'b0;
   assign count_out           = s.count;
   assign time_base_valid_out = s.tb_valid;
   assign timer_irq_out       = s.irq;
   assign osc_enable_out      = s.ctrl[CTRL_OSC_BIT];
   assign osc_pins_input_out  = s.ctrl[CTRL_OSC_BIT];

   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (rst_in);

   a_wrap_sets_flag: assert property (ovf |=> s.flag && (s.count == COUNT_RESET))
      else $error("Wrap did not set overflow flag");

   a_flag_sticky: assert property (
      s.flag && !(s.wr_pend && (s.wr_idx == IDX_FLAG)) |=> s.flag)
      else $error("Overflow flag dropped without a clear");

   a_irq_masked: assert property (!s.irq_en |-> !timer_irq_out)
      else $error("Interrupt raised while masked");

   a_irq_follows: assert property (s.flag && s.irq_en |-> timer_irq_out)
      else $error("Enabled flag gave no interrupt");

   a_stop_holds: assert property (
      !s.ctrl[CTRL_ON_BIT] && !wr_cnt && !cc_reset_in |=> $stable(s.count))
      else $error("Count moved while stopped");

   a_step_one: assert property (
      !wr_cnt && !cc_reset_in && s.ctrl[CTRL_ON_BIT] && tick
      |=> s.count == 16'($past(s.count) + 16'h1))
      else $error("Count did not step by one");

   a_write_wins: assert property (
      wr_low && cc_reset_in |=> s.count[7:0] == $past(hwdata_in[7:0]))
      else $error("Reset beat a count write");

   a_cc_clears: assert property (cc_reset_in && !wr_cnt |=> s.count == COUNT_RESET)
      else $error("Capture/compare reset did not clear count");

   a_sleep_frozen: assert property (
      sleep_in && !s.ctrl[CTRL_SYNC_BIT] && !wr_cnt && !cc_reset_in |=> $stable(s.count))
      else $error("Synchronised count moved in sleep");

   a_ctrl_upper: assert property (
      addr_ok && !hwrite_in && (addr_idx == IDX_CTRL) |=> hrdata_out[31:6] == 26'h0)
      else $error("Control upper bits not zero");

   a_base_invalid: assert property (
      s.ctrl[CTRL_CS_BIT] && s.ctrl[CTRL_SYNC_BIT] |-> !time_base_valid_out)
      else $error("Unsynchronised count offered as time base");

   a_base_valid: assert property (
      !(s.ctrl[CTRL_CS_BIT] && s.ctrl[CTRL_SYNC_BIT]) |-> time_base_valid_out)
      else $error("Synchronised count not offered as time base");

   a_osc_enable: assert property (
      s.wr_pend && (s.wr_idx == IDX_CTRL) |=> osc_enable_out == $past(hwdata_in[CTRL_OSC_BIT]))
      else $error("Oscillator enable did not follow control write");

   a_pins_input: assert property (
      s.wr_pend && (s.wr_idx == IDX_CTRL) |=> osc_pins_input_out == $past(hwdata_in[CTRL_OSC_BIT]))
      else $error("Oscillator pins not forced to input");

   a_ctrl_write: assert property (
      s.wr_pend && (s.wr_idx == IDX_CTRL) |=> s.ctrl == ($past(hwdata_in[7:0]) & CTRL_WMASK))
      else $error("Control write landed wrong");

   a_high_write: assert property (
      wr_high |=> s.count[15:8] == $past(hwdata_in[7:0]))
      else $error("High byte write landed wrong");

   a_low_write: assert property (
      wr_low |=> s.count[7:0] == $past(hwdata_in[7:0]))
      else $error("Low byte write landed wrong");

   a_pre_cleared: assert property (
      wr_cnt |=> u_prescaler.s.ripple == 3'h0)
      else $error("Count write left prescaler running");

   a_cc_no_flag: assert property (
      cc_reset_in && !s.flag && !(s.wr_pend && (s.wr_idx == IDX_FLAG)) |=> !s.flag)
      else $error("Capture/compare reset set the flag");

   a_sync_ignored: assert property (
      !s.ctrl[CTRL_CS_BIT] |-> tick == (tick_sync && !sleep_in))
      else $error("Sync bit acted on internal source");

   a_read_idle: assert property (
      !(addr_ok && !hwrite_in) |=> hrdata_out == 32'h0)
      else $error("Read data outside a data phase");

   a_read_low: assert property (
      addr_ok && !hwrite_in && (addr_idx == IDX_LOW) |=> hrdata_out == {24'h0, $past(s.count[7:0])})
      else $error("Low byte read wrong");

   a_read_high: assert property (
      addr_ok && !hwrite_in && (addr_idx == IDX_HIGH) |=> hrdata_out == {24'h0, $past(s.count[15:8])})
      else $error("High byte read wrong");

   a_timer_sleep: assert property (
      sleep_in && !s.ctrl[CTRL_CS_BIT] && !wr_cnt && !cc_reset_in |=> $stable(s.count))
      else $error("Timer mode count moved in sleep");

   a_bypass_runs: assert property (
      s.ctrl[CTRL_CS_BIT] && s.ctrl[CTRL_SYNC_BIT] && s.ctrl[CTRL_ON_BIT] && tick_byp && !wr_cnt && !cc_reset_in
      |=> s.count == 16'($past(s.count) + 16'h1))
      else $error("Unsynchronised count did not step");

   a_irq_wakes: assert property (
      ovf && s.irq_en && !(s.wr_pend && (s.wr_idx == IDX_ENABLE)) |=> timer_irq_out)
      else $error("Overflow gave no interrupt");

   a_osc_source: assert property (
      s.ctrl[CTRL_CS_BIT] && s.ctrl[CTRL_OSC_BIT] |-> src_level == s.osc_s2)
      else $error("Oscillator pin not used as source");

   a_phase_step: assert property (
      !sleep_in |=> s.phase == 2'($past(s.phase) + PHASE_STEP))
      else $error("Instruction phase did not advance");

   c_overflow:   cover property (ovf);
   c_cc_reset:   cover property (cc_reset_in && s.count != COUNT_RESET);
   c_async_wake: cover property (sleep_in && s.ctrl[CTRL_SYNC_BIT] && inc);
   c_prescale8:  cover property (s.ctrl[CTRL_PS_LSB +: 2] == 2'h3 && inc);
   c_write_beat: cover property (wr_cnt && cc_reset_in);

endmodule

/* File: design/stc_pkg.sv */
package stc_pkg;

   // Register indices; the bus byte address is four times the index
   localparam logic [9:0]  IDX_FLAG      = 10'h00c;
   localparam logic [9:0]  IDX_LOW       = 10'h00e;
   localparam logic [9:0]  IDX_HIGH      = 10'h00f;
   localparam logic [9:0]  IDX_CTRL      = 10'h010;
   localparam logic [9:0]  IDX_ENABLE    = 10'h08c;

   // Control field positions
   localparam int          CTRL_ON_BIT   = 0;
   localparam int          CTRL_CS_BIT   = 1;
   localparam int          CTRL_SYNC_BIT = 2;
   localparam int          CTRL_OSC_BIT  = 3;
   localparam int          CTRL_PS_LSB   = 4;
   localparam int          FLAG_BIT      = 0;
   localparam int          ENABLE_BIT    = 0;

   // Reset values and masks
   localparam logic [7:0]  CTRL_RESET    = 8'h00;
   localparam logic [7:0]  CTRL_WMASK    = 8'h3f;
   localparam logic [15:0] COUNT_RESET   = 16'h0000;
   localparam logic [15:0] COUNT_MAX     = 16'hffff;

   // Oscillator periods per instruction cycle
   localparam int          OSC_PER_INSTR = 4;
   localparam logic [1:0]  PHASE_STEP    = 2'h1;

endpackage

/* File: design/stc_prescaler.sv */
module stc_prescaler
   import stc_pkg::*;
(
   input  wire logic       clk_in,
   input  wire logic       rst_in,
   input  wire logic       level_in,
   input  wire logic       clear_in,
   input  wire logic [1:0] select_in,
   output logic            tap_out
);

   typedef struct packed {
      logic       prev;
      logic [2:0] ripple;
   } stc_pre_state_t;

   stc_pre_state_t s;
   stc_pre_state_t next_s;

   always_comb begin
      next_s      = s;
      next_s.prev = level_in;
      if (clear_in) begin
         next_s.ripple = 3'h0;
      end else if (level_in && !s.prev) begin
         next_s.ripple = 3'(s.ripple + 3'h1);
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // Divided taps are symmetrical square waves of the source
   always_comb begin
      case (select_in)
         2'h0:    tap_out = level_in;
         2'h1:    tap_out = s.ripple[0];
         2'h2:    tap_out = s.ripple[1];
         2'h3:    tap_out = s.ripple[2];
         default: tap_out = level_in;
      endcase
   end

endmodule

/* File: bench/stc_clk_source.sv */
module stc_clk_source (
   input  wire logic       core_clk_in,
   input  wire logic       start_in,
   input  wire logic [7:0] edges_in,
   input  wire logic       use_osc_in,
   output logic            ext_clock_pin_out,
   output logic            osc_input_pin_out,
   output logic            busy_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [8:0] left = 9'h000;
   logic [1:0] ph   = 2'h0;
   logic       lvl  = 1'b0;
   // Each level held four clocks, well past the sampling minimum
   always @(posedge core_clk_in) begin
      if (start_in) begin
         left <= {edges_in, 1'b0};
         ph <= 2'h0;
      end else if (left != 9'h000) begin
         ph <= ph + 2'h1;
         if (ph == 2'h3) begin
            lvl <= ~lvl;
            left <= left - 9'h001;
         end
      end
   end
   // Clock stands low between bursts, unselected pin stays idle
   assign ext_clock_pin_out = use_osc_in ? 1'b0 : lvl;
   assign osc_input_pin_out = use_osc_in ? lvl : 1'b0;
   assign busy_out          = (left != 9'h000);
endmodule

/* File: bench/stc_timer_tb_top.sv */
module stc_timer_tb_top
   import stc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic [7:0]  ctrl;
      logic [7:0]  rb;
      logic [15:0] span;
      logic [15:0] delta;
   } stc_row_t;
   logic        clk, rst, hsel, hwrite, sleep, cc, start, use_osc;
   logic        hready, hresp, ext_pin, osc_pin, busy, tbv, irq, osc_en, osc_in;
   logic [1:0]  htrans;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [15:0] cnt, c0;
   logic [7:0]  edges;
   int          err_count, num_checks;
   // Spans are whole prescale periods, so the step is exact whatever the phase
   stc_row_t    rows [6] = '{'{8'h01, 8'h01, 16'd32, 16'd8}, '{8'h15, 8'h15, 16'd64, 16'd8},
                             '{8'h21, 8'h21, 16'd128, 16'd8}, '{8'hf1, 8'h31, 16'd256, 16'd8},
                             '{8'h00, 8'h00, 16'd64, 16'd0}, '{8'h30, 8'h30, 16'd64, 16'd0}};

   stc_timer i_dut (.core_clk_in(clk), .rst_in(rst), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
      .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata),
      .hreadyout_out(hready), .hresp_out(hresp), .ext_clock_pin_in(ext_pin), .osc_input_pin_in(osc_pin),
      .sleep_in(sleep), .cc_reset_in(cc), .count_out(cnt), .time_base_valid_out(tbv), .timer_irq_out(irq),
      .osc_enable_out(osc_en), .osc_pins_input_out(osc_in));
   stc_clk_source i_src (.core_clk_in(clk), .start_in(start), .edges_in(edges), .use_osc_in(use_osc),
      .ext_clock_pin_out(ext_pin), .osc_input_pin_out(osc_pin), .busy_out(busy));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
      num_checks++;
      if (g !== e) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", name, e, g);
      end
   endtask

   task automatic xfer(input logic [9:0] idx, input logic [7:0] d, input logic wr, input logic c);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= {20'h00000, idx, 2'h0};
      htrans <= 2'h2;
      hwrite <= wr;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= {24'h000000, d};
      cc <= c;
      do @(posedge clk); while (hready !== 1'b1);
      rd = hrdata;
      cc <= 1'b0;
   endtask

   task automatic burst(input logic [7:0] n, input logic o);
      @(posedge clk);
      start <= 1'b1;
      edges <= n;
      use_osc <= o;
      @(posedge clk);
      start <= 1'b0;
      @(posedge clk);
      for (int i = 0; i < 4000 && busy; i++) @(posedge clk);
      // Pin synchroniser and sampling add a few clocks of lag
      repeat (12) @(posedge clk);
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   initial begin
      #400000;
      err_count++;
      close_out();
   end

   initial begin
      rst = 1'b1;
      hsel = 1'b0;
      haddr = 32'h00000000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h00000000;
      sleep = 1'b0;
      cc = 1'b0;
      start = 1'b0;
      edges = 8'h00;
      use_osc = 1'b0;
      err_count = 0;
      num_checks = 0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      xfer(IDX_CTRL, 8'h00, 1'b0, 1'b0);
      chk("control reset", 16'h0000, rd[15:0]);
      chk("count reset", 16'h0000, cnt);
      chk("response", 16'h0000, {15'h0000, hresp});
      xfer(IDX_LOW, 8'hfe, 1'b1, 1'b0);
      xfer(IDX_HIGH, 8'hff, 1'b1, 1'b0);
      xfer(IDX_LOW, 8'h00, 1'b0, 1'b0);
      chk("low byte", 16'h00fe, rd[15:0]);
      xfer(IDX_HIGH, 8'h00, 1'b0, 1'b0);
      chk("high byte", 16'h00ff, rd[15:0]);
      xfer(IDX_CTRL, 8'h01, 1'b1, 1'b0);
      repeat (40) @(posedge clk);
      xfer(IDX_CTRL, 8'h00, 1'b1, 1'b0);
      chk("count wrapped", 16'h0000, {8'h00, cnt[15:8]});
      xfer(IDX_FLAG, 8'h00, 1'b0, 1'b0);
      chk("flag", 16'h0001, {15'h0000, rd[0]});
      chk("irq masked", 16'h0000, {15'h0000, irq});
      xfer(IDX_ENABLE, 8'h01, 1'b1, 1'b0);
      repeat (2) @(posedge clk);
      chk("irq", 16'h0001, {15'h0000, irq});
      xfer(IDX_FLAG, 8'h00, 1'b1, 1'b0);
      repeat (2) @(posedge clk);
      chk("irq cleared", 16'h0000, {15'h0000, irq});
      xfer(IDX_ENABLE, 8'h00, 1'b1, 1'b0);
      foreach (rows[i]) begin
         xfer(IDX_CTRL, rows[i].ctrl, 1'b1, 1'b0);
         xfer(IDX_CTRL, 8'h00, 1'b0, 1'b0);
         chk("control", {8'h00, rows[i].rb}, rd[15:0]);
         @(posedge clk);
         c0 = cnt;
         repeat (rows[i].span) @(posedge clk);
         chk("count step", rows[i].delta, cnt - c0);
      end
      @(posedge clk);
      cc <= 1'b1;
      @(posedge clk);
      cc <= 1'b0;
      repeat (2) @(posedge clk);
      chk("count cleared", 16'h0000, cnt);
      xfer(IDX_FLAG, 8'h00, 1'b0, 1'b0);
      chk("flag after clear", 16'h0000, {15'h0000, rd[0]});
      xfer(IDX_LOW, 8'h5a, 1'b1, 1'b1);
      repeat (2) @(posedge clk);
      chk("write beats clear", 16'h005a, cnt);
      xfer(IDX_CTRL, 8'h03, 1'b1, 1'b0);
      xfer(IDX_LOW, 8'h00, 1'b1, 1'b0);
      burst(8'd5, 1'b0);
      chk("ext count", 16'h0005, cnt);
      xfer(IDX_CTRL, 8'h0b, 1'b1, 1'b0);
      repeat (2) @(posedge clk);
      chk("osc on", 16'h0003, {14'h0000, osc_en, osc_in});
      burst(8'd3, 1'b0);
      chk("ext pin ignored", 16'h0005, cnt);
      burst(8'd3, 1'b1);
      chk("osc pin count", 16'h0008, cnt);
      xfer(IDX_CTRL, 8'h33, 1'b1, 1'b0);
      xfer(IDX_LOW, 8'h00, 1'b1, 1'b0);
      repeat (2) @(posedge clk);
      chk("osc off", 16'h0000, {14'h0000, osc_en, osc_in});
      burst(8'd2, 1'b0);
      xfer(IDX_LOW, 8'h00, 1'b1, 1'b0);
      burst(8'd2, 1'b0);
      chk("prescale cleared", 16'h0000, cnt);
      burst(8'd2, 1'b0);
      chk("prescale eight", 16'h0001, cnt);
      xfer(IDX_CTRL, 8'h03, 1'b1, 1'b0);
      xfer(IDX_LOW, 8'h00, 1'b1, 1'b0);
      sleep <= 1'b1;
      burst(8'd4, 1'b0);
      chk("synced sleep", 16'h0000, cnt);
      xfer(IDX_CTRL, 8'h07, 1'b1, 1'b0);
      repeat (2) @(posedge clk);
      chk("time base", 16'h0000, {15'h0000, tbv});
      burst(8'd4, 1'b0);
      chk("unsynced sleep", 16'h0004, cnt);
      sleep <= 1'b0;
      close_out();
   end
endmodule
